/* hw/rilpr_defs.vh */
// Constants of the reference profile register bank: register indices,
// writable-bit masks, reset values and field positions.
// Byte address of a register is four times its index.
`ifndef RILPR_DEFS_VH
`define RILPR_DEFS_VH

`define RILPR_IDX_W          12
`define RILPR_IDX_PRIO       12'h45a
`define RILPR_IDX_BW_LOW     12'h45b
`define RILPR_IDX_BW_MID     12'h45c
`define RILPR_IDX_BW_HIGH    12'h45d
`define RILPR_IDX_NDIV_LOW   12'h45e
`define RILPR_IDX_NDIV_MID   12'h45f
`define RILPR_IDX_NDIV_HIGH  12'h460
`define RILPR_IDX_FRAC_LOW   12'h461
`define RILPR_IDX_FRAC_MID   12'h462
`define RILPR_IDX_FRAC_HIGH  12'h463
`define RILPR_IDX_MOD_LOW    12'h464
`define RILPR_IDX_MOD_MID    12'h465
`define RILPR_IDX_MOD_HIGH   12'h466
`define RILPR_IDX_STATUS     12'h480

`define RILPR_MASK_FULL      8'hff
`define RILPR_MASK_PRIO      8'h07
`define RILPR_MASK_BW_HIGH   8'h03
`define RILPR_MASK_NDIV_HIGH 8'h03

`define RILPR_RST_BYTE       8'h00
`define RILPR_RST_STATUS     4'h0

`define RILPR_PRIO_EN_BIT    0
`define RILPR_PRIO_MSB       2
`define RILPR_PRIO_LSB       1
`define RILPR_BW16_BIT       0
`define RILPR_FILT_BIT       1

`define RILPR_ST_APPLIED     0
`define RILPR_ST_BW_ZERO     1
`define RILPR_ST_MOD_ZERO    2
`define RILPR_ST_CHANGED     3

`endif

/* hw/rilpr_byte_reg.v */
// One byte-wide software register with a fixed mask of writable bits.
// Assumes the write strobe and data come from logic on the same clock.
`timescale 1ns/1ps
`include "rilpr_defs.vh"

module rilpr_byte_reg #(
  parameter [7:0] MASK  = `RILPR_MASK_FULL,
  parameter [7:0] RESET = `RILPR_RST_BYTE
) (
  // Clock and reset
  input  wire       hclk,
  input  wire       hresetn,
  // Write port
  input  wire       we,
  input  wire [7:0] wdata,
  // Stored value
  output wire [7:0] q
);

  reg [7:0] q_r;

  // Reserved bits never store, so they read back as zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= RESET & MASK;
    end else if (we) begin
      q_r <= wdata & MASK;
    end
  end

  assign q = q_r;

endmodule

/* hw/rilpr_apply.v */
// Holds the profile values presented to the loop control logic.
// Assumes the active-input select comes from switchover logic on hclk.
`timescale 1ns/1ps
`include "rilpr_defs.vh"

module rilpr_apply (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // Selection
  input  wire        active,
  input  wire        enable,
  // Programmed profile
  input  wire [16:0] bw,
  input  wire        filt,
  input  wire [17:0] ndiv,
  input  wire [23:0] frac,
  input  wire [23:0] modulus,
  // Applied profile
  output reg         applied,
  output reg  [16:0] bw_out,
  output reg         filt_out,
  output reg  [17:0] ndiv_out,
  output reg  [23:0] frac_out,
  output reg  [23:0] mod_out
);

  // Values follow the registers every cycle while applied; software
  // that rewrites a multi-byte field of a live profile sees torn values.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      applied  <= 1'b0;
      bw_out   <= 17'h00000;
      filt_out <= 1'b0;
      ndiv_out <= 18'h00000;
      frac_out <= 24'h000000;
      mod_out  <= 24'h000000;
    end else if (active && enable) begin
      applied  <= 1'b1;
      bw_out   <= bw;
      filt_out <= filt;
      ndiv_out <= ndiv;
      frac_out <= frac;
      mod_out  <= modulus;
    end else begin
      applied  <= 1'b0;
      bw_out   <= 17'h00000;
      filt_out <= 1'b0;
      ndiv_out <= 18'h00000;
      frac_out <= 24'h000000;
      mod_out  <= 24'h000000;
    end
  end

endmodule

/* hw/rilpr_top.v */
// Profile register bank of the third reference input for the first
// digital loop, reached over AHB-Lite, with its applied-profile outputs.
// Assumes a single AHB-Lite master and switchover logic on hclk.
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "rilpr_defs.vh"

module rilpr_top (
  // Clock and reset
  input  wire        hclk,
  input  wire        hresetn,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output wire [31:0] hrdata,
  // Switchover logic
  input  wire        ref_active,
  output wire        ref_enable,
  output wire [1:0]  ref_priority,
  // Applied profile to loop control
  output wire        profile_applied,
  output wire [16:0] loop_bandwidth,
  output wire        high_margin_filter,
  output wire [17:0] integer_feedback_divider,
  output wire [23:0] feedback_fraction_numerator,
  output wire [23:0] feedback_fraction_modulus
);

  localparam W = `RILPR_IDX_W;

  // Bus state
  reg          hreadyout_r;
  reg          hresp_r;
  reg  [31:0]  hrdata_r;
  reg          wr_pend_r;
  reg          rd_pend_r;
  reg  [W-1:0] addr_idx_r;
  reg          addr_ok_r;

  // Register contents
  wire [7:0]   prio_q;
  wire [7:0]   bw_low_q;
  wire [7:0]   bw_mid_q;
  wire [7:0]   bw_high_q;
  wire [7:0]   ndiv_low_q;
  wire [7:0]   ndiv_mid_q;
  wire [7:0]   ndiv_high_q;
  wire [7:0]   frac_low_q;
  wire [7:0]   frac_mid_q;
  wire [7:0]   frac_high_q;
  wire [7:0]   mod_low_q;
  wire [7:0]   mod_mid_q;
  wire [7:0]   mod_high_q;

  // Assembled fields
  wire [16:0]  bw_val;
  wire         filt_val;
  wire [17:0]  ndiv_val;
  wire [23:0]  frac_val;
  wire [23:0]  mod_val;

  // Decode and status
  wire         addr_phase;
  wire         addr_in_map;
  wire         wr_data;
  wire         profile_write;
  wire [3:0]   status_val;
  reg          changed_r;
  reg  [31:0]  rd_mux;

  // A transfer is taken only while the bus is ready and NONSEQ/SEQ
  assign addr_phase  = hsel && hready && htrans[1];
  assign addr_in_map = (haddr[31:14] == 18'h00000) &&
                       (haddr[1:0] == 2'b00);
  assign wr_data     = wr_pend_r && addr_ok_r;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'b0;
      rd_pend_r  <= 1'b0;
      addr_idx_r <= {W{1'b0}};
      addr_ok_r  <= 1'b0;
    end else begin
      if (addr_phase) begin
        wr_pend_r  <= hwrite;
        rd_pend_r  <= !hwrite;
        addr_idx_r <= haddr[13:2];
        addr_ok_r  <= addr_in_map;
      end else if (hreadyout_r) begin
        wr_pend_r  <= 1'b0;
        rd_pend_r  <= 1'b0;
      end else begin
        rd_pend_r  <= 1'b0;
      end
    end
  end

  // Reads take one wait state so the mux sees any write just finished
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
      hrdata_r    <= 32'h00000000;
    end else begin
      hresp_r <= 1'b0;
      if (addr_phase && !hwrite) begin
        hreadyout_r <= 1'b0;
      end else if (rd_pend_r && !hreadyout_r) begin
        hreadyout_r <= 1'b1;
        hrdata_r    <= addr_ok_r ? rd_mux : 32'h00000000;
      end else begin
        hreadyout_r <= 1'b1;
      end
    end
  end

  // Priority and enable
  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_PRIO),
    .RESET (`RILPR_RST_BYTE)
  ) u_prio (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_PRIO)),
    .wdata   (hwdata[7:0]),
    .q       (prio_q)
  );

  // Loop bandwidth and high-margin filter select
  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_bw_low (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_BW_LOW)),
    .wdata   (hwdata[7:0]),
    .q       (bw_low_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_bw_mid (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_BW_MID)),
    .wdata   (hwdata[7:0]),
    .q       (bw_mid_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_BW_HIGH),
    .RESET (`RILPR_RST_BYTE)
  ) u_bw_high (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_BW_HIGH)),
    .wdata   (hwdata[7:0]),
    .q       (bw_high_q)
  );

  // Integer feedback divider
  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_ndiv_low (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_NDIV_LOW)),
    .wdata   (hwdata[7:0]),
    .q       (ndiv_low_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_ndiv_mid (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_NDIV_MID)),
    .wdata   (hwdata[7:0]),
    .q       (ndiv_mid_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_NDIV_HIGH),
    .RESET (`RILPR_RST_BYTE)
  ) u_ndiv_high (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_NDIV_HIGH)),
    .wdata   (hwdata[7:0]),
    .q       (ndiv_high_q)
  );

  // Fraction numerator
  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_frac_low (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_FRAC_LOW)),
    .wdata   (hwdata[7:0]),
    .q       (frac_low_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_frac_mid (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_FRAC_MID)),
    .wdata   (hwdata[7:0]),
    .q       (frac_mid_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_frac_high (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_FRAC_HIGH)),
    .wdata   (hwdata[7:0]),
    .q       (frac_high_q)
  );

  // Fraction modulus
  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_mod_low (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_MOD_LOW)),
    .wdata   (hwdata[7:0]),
    .q       (mod_low_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_mod_mid (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_MOD_MID)),
    .wdata   (hwdata[7:0]),
    .q       (mod_mid_q)
  );

  rilpr_byte_reg #(
    .MASK  (`RILPR_MASK_FULL),
    .RESET (`RILPR_RST_BYTE)
  ) u_mod_high (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (wr_data && (addr_idx_r == `RILPR_IDX_MOD_HIGH)),
    .wdata   (hwdata[7:0]),
    .q       (mod_high_q)
  );

  // Field assembly, least significant byte at the lowest index
  assign bw_val   = {bw_high_q[`RILPR_BW16_BIT], bw_mid_q, bw_low_q};
  assign filt_val = bw_high_q[`RILPR_FILT_BIT];
  assign ndiv_val = {ndiv_high_q[1:0], ndiv_mid_q, ndiv_low_q};
  assign frac_val = {frac_high_q, frac_mid_q, frac_low_q};
  assign mod_val  = {mod_high_q, mod_mid_q, mod_low_q};

  // Any write to a profile byte; the flag below counts it only while the profile drives the loop
  assign profile_write = wr_data &&
                         (addr_idx_r >= `RILPR_IDX_BW_LOW) &&
                         (addr_idx_r <= `RILPR_IDX_MOD_HIGH);

  // Sticky flag; a new change in the clearing cycle keeps it set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      changed_r <= 1'b0;
    end else if (profile_write && profile_applied) begin
      changed_r <= 1'b1;
    end else if (wr_data && (addr_idx_r == `RILPR_IDX_STATUS) &&
                 hwdata[`RILPR_ST_CHANGED]) begin
      changed_r <= 1'b0;
    end
  end

  // Zero bandwidth is undefined loop behaviour; flagged, not blocked
  assign status_val[`RILPR_ST_APPLIED] = profile_applied;
  assign status_val[`RILPR_ST_BW_ZERO] = prio_q[`RILPR_PRIO_EN_BIT] &&
                                         (bw_val == 17'h00000);
  assign status_val[`RILPR_ST_MOD_ZERO] = (frac_val != 24'h000000) &&
                                          (mod_val == 24'h000000);
  assign status_val[`RILPR_ST_CHANGED] = changed_r;

  always @* begin
    rd_mux = 32'h00000000;
    case (addr_idx_r)
      `RILPR_IDX_PRIO:      rd_mux = {24'h000000, prio_q};
      `RILPR_IDX_BW_LOW:    rd_mux = {24'h000000, bw_low_q};
      `RILPR_IDX_BW_MID:    rd_mux = {24'h000000, bw_mid_q};
      `RILPR_IDX_BW_HIGH:   rd_mux = {24'h000000, bw_high_q};
      `RILPR_IDX_NDIV_LOW:  rd_mux = {24'h000000, ndiv_low_q};
      `RILPR_IDX_NDIV_MID:  rd_mux = {24'h000000, ndiv_mid_q};
      `RILPR_IDX_NDIV_HIGH: rd_mux = {24'h000000, ndiv_high_q};
      `RILPR_IDX_FRAC_LOW:  rd_mux = {24'h000000, frac_low_q};
      `RILPR_IDX_FRAC_MID:  rd_mux = {24'h000000, frac_mid_q};
      `RILPR_IDX_FRAC_HIGH: rd_mux = {24'h000000, frac_high_q};
      `RILPR_IDX_MOD_LOW:   rd_mux = {24'h000000, mod_low_q};
      `RILPR_IDX_MOD_MID:   rd_mux = {24'h000000, mod_mid_q};
      `RILPR_IDX_MOD_HIGH:  rd_mux = {24'h000000, mod_high_q};
      `RILPR_IDX_STATUS:    rd_mux = {28'h0000000, status_val};
      default:              rd_mux = 32'h00000000;
    endcase
  end

  // Profile reaches the loop only while enabled and chosen
  rilpr_apply u_apply (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .active   (ref_active),
    .enable   (prio_q[`RILPR_PRIO_EN_BIT]),
    .bw       (bw_val),
    .filt     (filt_val),
    .ndiv     (ndiv_val),
    .frac     (frac_val),
    .modulus  (mod_val),
    .applied  (profile_applied),
    .bw_out   (loop_bandwidth),
    .filt_out (high_margin_filter),
    .ndiv_out (integer_feedback_divider),
    .frac_out (feedback_fraction_numerator),
    .mod_out  (feedback_fraction_modulus)
  );

  assign ref_enable   = prio_q[`RILPR_PRIO_EN_BIT];
  assign ref_priority = prio_q[`RILPR_PRIO_MSB:`RILPR_PRIO_LSB];
  assign hreadyout    = hreadyout_r;
  assign hresp        = hresp_r;
  assign hrdata       = hrdata_r;

endmodule

/* verification/rilpr_top_properties.sv */
// Bus and applied-profile properties of the reference profile bank.
// Assumes hready is tied to hreadyout and a single master on hclk.
`timescale 1ns/1ps
`include "rilpr_defs.vh"

module rilpr_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // AHB-Lite slave
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Switchover and applied profile
  input wire logic        ref_active,
  input wire logic        ref_enable,
  input wire logic [1:0]  ref_priority,
  input wire logic        profile_applied,
  input wire logic [16:0] loop_bandwidth,
  input wire logic        high_margin_filter,
  input wire logic [17:0] integer_feedback_divider,
  input wire logic [23:0] feedback_fraction_numerator,
  input wire logic [23:0] feedback_fraction_modulus
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire        take = hsel & hready & htrans[1];
  wire [11:0] idx  = haddr[13:2];
  wire        hit  = (haddr[31:14] == 18'h0) && (haddr[1:0] == 2'b00);
  wire [83:0] prof = {loop_bandwidth, high_margin_filter,
    integer_feedback_divider, feedback_fraction_numerator,
    feedback_fraction_modulus};
  logic       wr_prio_r;
  logic       wr_prof_r;

  // Flags mark the data phase of a write, when the register changes
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_prio_r <= 1'b0;
      wr_prof_r <= 1'b0;
    end else if (hready) begin
      wr_prio_r <= take & hwrite & hit & (idx == `RILPR_IDX_PRIO);
      wr_prof_r <= take & hwrite & hit & (idx >= `RILPR_IDX_BW_LOW) &
                   (idx <= `RILPR_IDX_MOD_HIGH);
    end
  end

  property p_en_off;
    !ref_enable |=> !profile_applied;
  endproperty
  a_en_off: assert property (p_en_off) else $error("applied while off");
  property p_applied;
    profile_applied == ($past(ref_active) && $past(ref_enable));
  endproperty
  a_applied: assert property (p_applied) else $error("applied wrong");
  property p_zero;
    !profile_applied |-> prof == 84'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("profile not zero");
  property p_prio_hold;
    !wr_prio_r |=> $stable({ref_priority, ref_enable});
  endproperty
  a_prio_hold: assert property (p_prio_hold) else $error("prio moved");
  property p_prof_hold;
    profile_applied && ref_active && ref_enable && !wr_prof_r &&
      !$past(wr_prof_r) |=> $stable(prof);
  endproperty
  a_prof_hold: assert property (p_prof_hold)
    else $error("profile moved");
  property p_rd_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_fast;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_rdata_hi;
    hresp == 1'b0 && hrdata[31:8] == 24'h0;
  endproperty
  a_rdata_hi: assert property (p_rdata_hi)
    else $error("upper bits set");

  c_read: cover property (take && !hwrite ##2 hreadyout);
  c_apply: cover property ($rose(profile_applied));
  c_prio: cover property (wr_prio_r ##1 ref_enable);
endmodule

bind rilpr_top rilpr_chk rilpr_chk_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .ref_active(ref_active), .ref_enable(ref_enable),
  .ref_priority(ref_priority), .profile_applied(profile_applied),
  .loop_bandwidth(loop_bandwidth), .high_margin_filter(high_margin_filter),
  .integer_feedback_divider(integer_feedback_divider),
  .feedback_fraction_numerator(feedback_fraction_numerator),
  .feedback_fraction_modulus(feedback_fraction_modulus));

/* verification/rilpr_top_tb.sv */
// Self-checking bench of the reference profile bank over AHB-Lite.
// Assumes the bank answers reads after one wait state, writes at once.
`timescale 1ns/1ps
`include "rilpr_defs.vh"

module rilpr_top_tb;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic        ref_active = 1'b0;
  wire         hreadyout;
  wire         hresp;
  wire  [31:0] hrdata;
  wire         ref_enable;
  wire  [1:0]  ref_priority;
  wire         profile_applied;
  wire  [16:0] bw;
  wire         filt;
  wire  [17:0] ndiv;
  wire  [23:0] frac;
  wire  [23:0] modu;
  int          errors = 0;
  int          checks = 0;
  int          n;
  logic [31:0] d;
  logic [7:0]  pv [13] = '{8'h05, 8'hcd, 8'hab, 8'h03, 8'h34, 8'h12,
                           8'h02, 8'h12, 8'h34, 8'h56, 8'h56, 8'h78, 8'h9a};

  always #2.5 hclk = ~hclk;

  rilpr_top rilpr_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ref_active(ref_active), .ref_enable(ref_enable),
    .ref_priority(ref_priority), .profile_applied(profile_applied),
    .loop_bandwidth(bw), .high_margin_filter(filt),
    .integer_feedback_divider(ndiv), .feedback_fraction_numerator(frac),
    .feedback_fraction_modulus(modu));

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Address phase held until the slave is ready to take it
  task automatic ap(input logic [11:0] i, input logic w);
    hsel   <= 1'b1;
    haddr  <= {18'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
  endtask

  task automatic wr(input logic [11:0] i, input logic [7:0] v);
    ap(i, 1'b1);
    hwdata <= {24'h0, v};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] i, output logic [31:0] v);
    ap(i, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask

  function automatic logic [7:0] msk(input int k);
    case (k)
      0: msk = 8'h07;
      3, 6: msk = 8'h03;
      default: msk = 8'hff;
    endcase
  endfunction

  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this allows ample margin
  initial begin
    #20000;
    errors++;
    stop_test;
  end

  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (n = 0; n < 13; n++) begin
      rd(`RILPR_IDX_PRIO + n[11:0], d);
      chk(d, 32'h0);
    end
    chk({11'h0, ref_enable, ref_priority, profile_applied, bw}, 32'h0);
    chk({14'h0, ndiv}, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test reset values done");
    for (n = 0; n < 13; n++) begin
      wr(`RILPR_IDX_PRIO + n[11:0], 8'hff);
      rd(`RILPR_IDX_PRIO + n[11:0], d);
      chk(d, {24'h0, msk(n)});
    end
    wr(`RILPR_IDX_MOD_HIGH + 12'h1, 8'hff);
    rd(`RILPR_IDX_MOD_HIGH + 12'h1, d);
    chk(d, 32'h0);
    $display("test writable bits done");
    for (n = 0; n < 13; n++) begin
      wr(`RILPR_IDX_PRIO + n[11:0], pv[n]);
    end
    repeat (2) @(posedge hclk);
    chk({30'h0, ref_priority}, 32'h2);
    chk({31'h0, ref_enable}, 32'h1);
    chk({14'h0, profile_applied, bw}, 32'h0);
    ref_active <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, profile_applied}, 32'h1);
    chk({15'h0, bw}, 32'h1abcd);
    chk({31'h0, filt}, 32'h1);
    chk({14'h0, ndiv}, 32'h21234);
    chk({8'h0, frac}, 32'h563412);
    chk({8'h0, modu}, 32'h9a7856);
    // Drop to a band where the normal filter is acceptable
    wr(`RILPR_IDX_BW_MID, 8'h13);
    wr(`RILPR_IDX_BW_HIGH, 8'h00);
    repeat (2) @(posedge hclk);
    chk({15'h0, bw}, 32'h013cd);
    chk({31'h0, filt}, 32'h0);
    rd(`RILPR_IDX_STATUS, d);
    chk(d, 32'h9);
    wr(`RILPR_IDX_STATUS, 8'h08);
    rd(`RILPR_IDX_STATUS, d);
    chk(d, 32'h1);
    $display("test profile fields done");
    for (n = 0; n < 4; n++) begin
      wr(`RILPR_IDX_PRIO, {5'h0, n[1:0], 1'b1});
      repeat (2) @(posedge hclk);
      chk({30'h0, ref_priority}, n);
      chk({31'h0, profile_applied}, 32'h1);
    end
    wr(`RILPR_IDX_PRIO, 8'h06);
    repeat (2) @(posedge hclk);
    chk({profile_applied, bw, ndiv[13:0]}, 32'h0);
    wr(`RILPR_IDX_PRIO, 8'h01);
    ref_active <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({6'h0, profile_applied, filt, frac}, 32'h0);
    $display("test enable and priority done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`RILPR_IDX_FRAC_HIGH, d);
    chk(d, 32'h0);
    chk({5'h0, ref_enable, ref_priority, modu}, 32'h0);
    $display("test second reset done");
    stop_test;
  end
endmodule
